// *** core/afe_mode_cfg.svh ***
`ifndef AFE_MODE_CFG_SVH
`define AFE_MODE_CFG_SVH
// command width and mode field
`define CMD_BITS         8
`define MODE_LSB         0
`define MODE_MSB         2
// mode codes
`define MODE_SHUTDOWN    3'h0
`define MODE_IDLE        3'h1
`define MODE_RX          3'h2
`define MODE_TX          3'h3
`define MODE_XCVR        3'h4
`define MODE_STANDBY     3'h5
// system clock period in ns
`define CLK_PERIOD_NS    10
// delays in microseconds, cycles rounded down is exact here
`define WAKE_LONG_US     40
`define WAKE_RX_US       20
`define WAKE_IDLE_US     10
`define RECOVER_US       10
`define WAKE_LONG_CYC    ((`WAKE_LONG_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_RX_CYC      ((`WAKE_RX_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_IDLE_CYC    ((`WAKE_IDLE_US * 1000) / `CLK_PERIOD_NS)
`define RECOVER_CYC      ((`RECOVER_US * 1000) / `CLK_PERIOD_NS)
// least chip select high time between writes
`define CS_HIGH_NS       80
`define CS_HIGH_CYC      ((`CS_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// host serial clock divider: reload count, half period is this plus one system cycles
`define SCLK_HALF_CYC    7
// reset value of the mode latch
`define MODE_RESET       3'h0
`endif

// *** core/afe_mode_pkg.sv ***
package afe_mode_pkg;
   // operating modes
   typedef enum logic [2:0] {
      mode_shutdown = 3'h0,
      mode_idle     = 3'h1,
      mode_rx       = 3'h2,
      mode_tx       = 3'h3,
      mode_xcvr     = 3'h4,
      mode_standby  = 3'h5
   } op_mode_t;
   // host sequencer states
   typedef enum {
      h_idle,
      h_select,
      h_low,
      h_high,
      h_release,
      h_gap
   } host_state_t;
endpackage

// *** core/afe_serial_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-wire write-only control link
interface afe_serial_if;
   logic cs_n;   // chip select, active low
   logic sclk;   // serial clock from host
   logic din;    // serial data, msb first
   modport device (input cs_n, input sclk, input din);
   modport host (output cs_n, output sclk, output din);
endinterface
`default_nettype wire

// *** core/afe_serial_mode_control.sv ***
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "afe_mode_cfg.svh"
module afe_serial_mode_control
   import afe_mode_pkg::*;
(
   input  wire logic        clk_sys,         // system clock
   input  wire logic        reset,           // synchronous, active high
   afe_serial_if.device     link,            // serial control link
   input  wire logic        conv_clk_static, // conversion clock held still
   input  wire logic [7:0]  adc_word,        // newest converted word
   input  wire logic        adc_word_valid,  // new word strobe
   output logic [2:0]       mode,            // latched operating mode
   output logic             ref_on,          // reference powered
   output logic             clk_dist_on,     // clock distribution powered
   output logic             adc_on,          // pipeline adcs powered
   output logic             dac_on,          // dacs powered
   output logic [7:0]       adc_output_bus,  // adc bus data
   output logic             adc_bus_oe,      // adc bus driven
   output logic             dac_data_clear,  // pulse: drop stored dac data
   output logic             converters_ready // wake or recovery done
);
   // complete state of the device end
   typedef struct packed {
      logic [1:0]  cs_sync;    // chip select synchroniser
      logic [1:0]  sclk_sync;  // serial clock synchroniser
      logic [1:0]  din_sync;   // data synchroniser
      logic        sclk_prev;  // last synced serial clock
      logic        cs_prev;    // last synced chip select
      logic [7:0]  shift;      // input shift register
      logic [3:0]  nbits;      // bits taken in this frame
      logic [2:0]  mode;       // mode latch
      logic [7:0]  held_word;  // last converted word
      logic [15:0] wait_cnt;   // wake or recovery countdown
      logic        clear;      // dac clear pulse
   } dev_state_t;

   dev_state_t st;       // registered state
   dev_state_t next_st;  // next state

   logic       sclk_rise;   // rising serial clock edge
   logic       cs_fall;     // frame start
   logic       cs_rise;     // frame end
   logic [2:0] new_mode;    // mode carried by a full frame
   logic [15:0] delay;      // delay for the transition

   // delay for a move from one mode to another
   function automatic logic [15:0] pick_delay(input logic [2:0] from,
                                              input logic [2:0] to,
                                              input logic       stat);
      logic active_to;
      logic active_from;
      active_to   = (to == `MODE_RX) || (to == `MODE_TX) || (to == `MODE_XCVR);
      active_from = (from == `MODE_RX) || (from == `MODE_TX) || (from == `MODE_XCVR);
      pick_delay  = 16'h0;
      if (!active_to) begin
         pick_delay = 16'h0;
      end else if (active_from) begin
         pick_delay = 16'((from == to) ? 0 : `RECOVER_CYC);
      end else if (from == `MODE_SHUTDOWN) begin
         pick_delay = 16'((to == `MODE_RX) ? `WAKE_RX_CYC : `WAKE_LONG_CYC);
      end else if (from == `MODE_IDLE) begin
         pick_delay = 16'(stat ? `WAKE_LONG_CYC : `WAKE_IDLE_CYC);
      end else begin
         pick_delay = 16'(`WAKE_LONG_CYC);
      end
   endfunction

   // edge detection on synchronised link signals
   always_comb begin
      sclk_rise = st.sclk_sync[1] && !st.sclk_prev;
      cs_fall   = !st.cs_sync[1] && st.cs_prev;
      cs_rise   = st.cs_sync[1] && !st.cs_prev;
      new_mode  = st.shift[`MODE_MSB:`MODE_LSB];
      delay     = pick_delay(st.mode, new_mode, conv_clk_static);
   end

   // next state
   always_comb begin
      next_st = st;
      next_st.cs_sync   = {st.cs_sync[0], link.cs_n};
      next_st.sclk_sync = {st.sclk_sync[0], link.sclk};
      next_st.din_sync  = {st.din_sync[0], link.din};
      next_st.sclk_prev = st.sclk_sync[1];
      next_st.cs_prev   = st.cs_sync[1];
      next_st.clear     = 1'b0;
      // hold last converted word while adcs run
      if (adc_word_valid && adc_on) begin
         next_st.held_word = adc_word;
      end
      // countdown toward converters ready
      if (st.wait_cnt != 16'h0) begin
         next_st.wait_cnt = st.wait_cnt - 16'h1;
      end
      // serial port, alive in every mode
      if (cs_fall) begin
         next_st.nbits = 4'h0;
      end else if (!st.cs_sync[1] && sclk_rise && st.nbits != 4'(`CMD_BITS)) begin
         next_st.shift = {st.shift[6:0], st.din_sync[1]};
         next_st.nbits = st.nbits + 4'h1;
      end
      // latch a full frame at chip select rise
      if (cs_rise) begin
         if (st.nbits == 4'(`CMD_BITS)) begin
            next_st.mode     = new_mode;
            next_st.wait_cnt = delay;
            if (st.mode == `MODE_SHUTDOWN && new_mode != `MODE_SHUTDOWN) begin
               next_st.clear = 1'b1;
            end
         end
         next_st.nbits = 4'h0;
      end
   end

   // register the state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= '0;
         st.cs_sync   <= 2'h3;
         st.cs_prev   <= 1'b1;
         st.mode      <= `MODE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // mode decode to power and bus controls
   always_comb begin
      mode        = st.mode;
      ref_on      = 1'b0;
      clk_dist_on = 1'b0;
      adc_on      = 1'b0;
      dac_on      = 1'b0;
      unique case (st.mode)
         `MODE_SHUTDOWN: ref_on = 1'b0;
         `MODE_IDLE:     begin ref_on = 1'b1; clk_dist_on = 1'b1; end
         `MODE_RX:       begin ref_on = 1'b1; clk_dist_on = 1'b1; adc_on = 1'b1; end
         `MODE_TX:       begin ref_on = 1'b1; clk_dist_on = 1'b1; dac_on = 1'b1; end
         `MODE_XCVR:     begin
            ref_on = 1'b1;
            clk_dist_on = 1'b1;
            adc_on = 1'b1;
            dac_on = 1'b1;
         end
         `MODE_STANDBY:  ref_on = 1'b1;
         default:        ref_on = 1'b0;                         // codes 110, 111
      endcase
   end

   // outputs
   assign adc_output_bus   = st.held_word;
   assign adc_bus_oe       = adc_on;
   assign dac_data_clear   = st.clear;
   assign converters_ready = (adc_on || dac_on) && (st.wait_cnt == 16'h0);
endmodule
`default_nettype wire

// *** core/afe_serial_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afe_mode_cfg.svh"
module afe_serial_host
   import afe_mode_pkg::*;
(
   input  wire logic        clk_sys,      // system clock
   input  wire logic        reset,        // synchronous, active high
   afe_serial_if.host       link,         // serial control link
   input  wire logic        avs_read,     // avalon read
   input  wire logic        avs_write,    // avalon write
   input  wire logic [3:0]  avs_address,  // byte address
   input  wire logic [31:0] avs_writedata,// write data
   output logic [31:0]      avs_readdata, // read data
   output logic             avs_waitrequest // stall
);
   // complete state of the host end
   typedef struct packed {
      host_state_t st;      // sequencer state
      logic [7:0]  shift;   // outgoing command
      logic [7:0]  last;    // last sent command
      logic [3:0]  nbits;   // bits left
      logic [7:0]  tick;    // divider count
      logic        cs_n;    // chip select
      logic        sclk;    // serial clock
      logic        din;     // data
   } host_st_t;

   host_st_t s;       // registered
   host_st_t next_s;  // next

   logic busy;        // frame in flight
   logic wr_cmd;      // write to command register
   assign busy   = (s.st != h_idle);
   assign wr_cmd = avs_write && (avs_address == 4'h0);

   // bus answers: command write stalls while busy
   always_comb begin
      avs_waitrequest = wr_cmd && busy;
      avs_readdata    = 32'h0;
      if (!avs_read) begin
         avs_readdata = 32'h0;                   // no read in flight
      end else if (avs_address == 4'h0) begin
         avs_readdata = {24'h0, s.last};         // last command
      end else if (avs_address == 4'h4) begin
         avs_readdata = {31'h0, busy};           // busy flag
      end
   end

   // frame sequencer
   always_comb begin
      next_s = s;
      if (s.tick != 8'h0) begin
         next_s.tick = s.tick - 8'h1;
      end
      unique case (s.st)
         h_idle: begin
            if (wr_cmd) begin
               next_s.shift = avs_writedata[7:0];
               next_s.last  = avs_writedata[7:0];
               next_s.cs_n  = 1'b0;
               next_s.nbits = 4'h8;
               next_s.tick  = 8'(`SCLK_HALF_CYC);
               next_s.st    = h_select;
            end
         end
         h_select: begin
            if (s.tick == 8'h0) begin
               next_s.din  = s.shift[7];
               next_s.tick = 8'(`SCLK_HALF_CYC);
               next_s.st   = h_low;
            end
         end
         h_low: begin
            if (s.tick == 8'h0) begin
               next_s.sclk  = 1'b1;
               next_s.shift = {s.shift[6:0], 1'b0};
               next_s.nbits = s.nbits - 4'h1;
               next_s.tick  = 8'(`SCLK_HALF_CYC);
               next_s.st    = h_high;
            end
         end
         h_high: begin
            if (s.tick == 8'h0) begin
               next_s.sclk = 1'b0;
               next_s.din  = s.shift[7];
               next_s.tick = 8'(`SCLK_HALF_CYC);
               next_s.st   = (s.nbits == 4'h0) ? h_release : h_low;
            end
         end
         h_release: begin
            if (s.tick == 8'h0) begin
               next_s.cs_n = 1'b1;
               next_s.tick = 8'(`CS_HIGH_CYC + `SCLK_HALF_CYC);
               next_s.st   = h_gap;
            end
         end
         h_gap: begin
            if (s.tick == 8'h0) begin
               next_s.st = h_idle;
            end
         end
      endcase
   end

   // register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s      <= '0;
         s.st   <= h_idle;
         s.cs_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign link.cs_n = s.cs_n;
   assign link.sclk = s.sclk;
   assign link.din  = s.din;
endmodule
`default_nettype wire

// *** verification/afe_serial_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the joined link and the device outputs
module afe_serial_properties (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic [2:0] mode,
   input wire logic       ref_on,
   input wire logic       clk_dist_on,
   input wire logic       adc_on,
   input wire logic       dac_on,
   input wire logic [7:0] adc_output_bus,
   input wire logic       adc_bus_oe,
   input wire logic       dac_data_clear,
   input wire logic       converters_ready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // power pattern per mode code
   shutdown_all_off_a: assert property (mode == 3'h0 |-> !ref_on && !clk_dist_on && !adc_on && !dac_on)
      else $error("shutdown leaves power on");
   idle_power_a: assert property (mode == 3'h1 |-> ref_on && clk_dist_on && !adc_on && !dac_on)
      else $error("idle power pattern wrong");
   rx_power_a: assert property (mode == 3'h2 |-> ref_on && adc_on && !dac_on)
      else $error("receive power pattern wrong");
   tx_power_a: assert property (mode == 3'h3 |-> ref_on && !adc_on && dac_on)
      else $error("transmit power pattern wrong");
   xcvr_power_a: assert property (mode == 3'h4 |-> ref_on && adc_on && dac_on)
      else $error("duplex power pattern wrong");
   standby_power_a: assert property (mode == 3'h5 |-> ref_on && !adc_on && !dac_on)
      else $error("standby power pattern wrong");
   // bus driven exactly while the adcs run
   bus_oe_match_a: assert property (adc_bus_oe == adc_on)
      else $error("adc bus enable differs from adc power");
   // held word frozen while tri-stated
   held_word_a: assert property (!adc_bus_oe && $past(!adc_bus_oe) |-> $stable(adc_output_bus))
      else $error("held adc word moved while off");
   // mode only moves once chip select is back high
   latch_at_rise_a: assert property (!$stable(mode) |-> cs_n)
      else $error("mode changed inside a frame");
   // converters not ready right after a change
   ready_drop_a: assert property (!$stable(mode) |=> !converters_ready)
      else $error("ready stayed high across a mode change");
   clear_pulse_a: assert property (dac_data_clear |=> !dac_data_clear)
      else $error("dac clear longer than one cycle");
   shutdown_exit_a: assert property ($past(mode) == 3'h0 && mode != 3'h0
      |-> ($past(dac_data_clear) || dac_data_clear) or (##1 dac_data_clear))
      else $error("no dac clear on leaving shutdown");
endmodule
`default_nettype wire

// *** verification/test_afe_serial_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afe_mode_cfg.svh"
module test_afe_serial_mode_control;
   logic        clk_sys, reset, conv_clk_static, adc_word_valid, avs_read, avs_write;
   logic [7:0]  adc_word, adc_output_bus, last_word;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest, ref_on, clk_dist_on, adc_on, dac_on;
   logic        adc_bus_oe, dac_data_clear, converters_ready;
   logic [2:0]  mode, mode2;
   int          errors, n_compared;
   afe_serial_if link();   // host to device
   afe_serial_if link2();  // bench to second device
   afe_serial_host u_afe_serial_host (.clk_sys(clk_sys), .reset(reset), .link(link),
      .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   afe_serial_mode_control u_afe_serial_mode_control (.clk_sys(clk_sys), .reset(reset),
      .link(link), .conv_clk_static(conv_clk_static), .adc_word(adc_word),
      .adc_word_valid(adc_word_valid), .mode(mode), .ref_on(ref_on),
      .clk_dist_on(clk_dist_on), .adc_on(adc_on), .dac_on(dac_on),
      .adc_output_bus(adc_output_bus), .adc_bus_oe(adc_bus_oe),
      .dac_data_clear(dac_data_clear), .converters_ready(converters_ready));
   afe_serial_mode_control u_afe_serial_mode_control_2 (.clk_sys(clk_sys), .reset(reset),
      .link(link2), .conv_clk_static(1'b0), .adc_word(8'h00), .adc_word_valid(1'b0),
      .mode(mode2), .ref_on(), .clk_dist_on(), .adc_on(), .dac_on(), .adc_output_bus(),
      .adc_bus_oe(), .dac_data_clear(), .converters_ready());
   afe_serial_properties u_afe_serial_properties (.clk_sys(clk_sys), .reset(reset),
      .cs_n(link.cs_n), .mode(mode), .ref_on(ref_on), .clk_dist_on(clk_dist_on),
      .adc_on(adc_on), .dac_on(dac_on), .adc_output_bus(adc_output_bus),
      .adc_bus_oe(adc_bus_oe), .dac_data_clear(dac_data_clear),
      .converters_ready(converters_ready));
   // verdict and end of run
   task automatic conclude();
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   // avalon cycle, waitrequest sampled just before each edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      logic w;
      @(posedge clk_sys);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      for (int i = 0; i < 600; i++) begin
         @(negedge clk_sys);
         w = avs_waitrequest;
         q = avs_readdata;
         @(posedge clk_sys);
         if (w === 1'b0) break;
         if (i == 599) begin
            check(1'b0, "waitrequest timeout");
            conclude();
         end
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // wait for chip select level on the host link
   task automatic wait_cs(input logic lvl);
      for (int i = 0; i < 400 && link.cs_n !== lvl; i++) begin
         @(negedge clk_sys);
         if (i == 399) begin
            check(1'b0, "chip select timeout");
            conclude();
         end
      end
   endtask
   // expected settle time in cycles
   function automatic int wake(input logic [2:0] f, input logic [2:0] t, input logic st);
      if (t < 3'h2 || t > 3'h4 || f == t) return 0;
      case (f)
         3'h0: return (t == 3'h2) ? `WAKE_RX_CYC : `WAKE_LONG_CYC;
         3'h1: return st ? `WAKE_LONG_CYC : `WAKE_IDLE_CYC;
         3'h5: return `WAKE_LONG_CYC;
         default: return `RECOVER_CYC;
      endcase
   endfunction
   // one command through the host, then timing and state checks
   task automatic step(input logic [7:0] cmd, input logic st);
      logic [31:0] q;
      logic [7:0]  w;
      int          d, n;
      d = wake(mode, cmd[2:0], st);
      conv_clk_static <= st;
      bus(1'b1, 4'h0, {24'h0, cmd}, q);
      wait_cs(1'b0);
      wait_cs(1'b1);
      // delays run from the latch, a few cycles after chip select rises
      for (n = 0; n < 20 && mode !== cmd[2:0]; n++) @(negedge clk_sys);
      for (n = 0; n < d + 60 && converters_ready !== 1'b1; n++) @(negedge clk_sys);
      if (cmd[2:0] >= 3'h2 && cmd[2:0] <= 3'h4)
         check(n >= d && n <= d + 8, "settle time");
      else
         check(converters_ready === 1'b0, "ready while off");
      check(mode === cmd[2:0], "latched mode");
      bus(1'b0, 4'h0, 32'h0, q);
      check(q[7:0] === cmd, "command readback");
      if (adc_bus_oe === 1'b1) check(adc_output_bus === last_word, "held word");
      for (int i = 0; i < 3 && adc_on === 1'b1; i++) begin
         @(posedge clk_sys);
         w = $urandom;
         adc_word <= w;
         adc_word_valid <= 1'b1;
         last_word = w;
      end
      @(posedge clk_sys);
      adc_word_valid <= 1'b0;
   endtask
   // bit-banged frame on the second link, free-running phase
   task automatic bang(input logic [9:0] v, input int n, input logic idle);
      link2.sclk <= idle;
      #62.5 link2.cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #62.5 link2.sclk <= 1'b0;
         link2.din <= v[i];
         #62.5 link2.sclk <= 1'b1;
      end
      #62.5 link2.sclk <= idle;
      link2.din <= ~link2.din;
      #62.5 link2.cs_n <= 1'b1;
      #200;
      repeat (10) @(posedge clk_sys);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // main sequence
   initial begin
      logic [2:0]  codes [18] = '{2, 3, 4, 1, 4, 5, 4, 0, 3, 1, 2, 0, 4, 2, 5, 2, 6, 0};
      logic [31:0] q;
      {reset, conv_clk_static, adc_word_valid, avs_read, avs_write} = 5'h10;
      {adc_word, last_word, avs_address, avs_writedata} = '0;
      {link2.cs_n, link2.sclk, link2.din} = 3'h4;
      errors = 0;
      n_compared = 0;
      void'($urandom(32'hd6a6));
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      check(mode === 3'h0 && converters_ready === 1'b0 && adc_bus_oe === 1'b0, "reset");
      foreach (codes[i]) step({5'($urandom), codes[i]}, i == 10);
      repeat (6) step({5'($urandom), 3'($urandom_range(0, 5))}, 1'($urandom));
      bus(1'b0, 4'h8, 32'h0, q);
      check(q === 32'h0, "unmapped read");
      bus(1'b0, 4'h4, 32'h0, q);
      check(q === 32'h0, "status busy while idle");
      bang(10'h0eb, 8, 1'b1);
      check(mode2 === 3'h3, "sclk idle high frame");
      bang(10'h004, 5, 1'b0);
      check(mode2 === 3'h3, "short frame");
      bang(10'h00b, 10, 1'b0);
      check(mode2 === 3'h2, "long frame keeps first byte");
      conclude();
   end
endmodule
`default_nettype wire
